// file: hw/cpsm_top.sv
// configuration port state machine: key entry, index/data ports, config regs
// assumes an i/o master on clock with one-cycle strobes and read data a cycle later;
// host reset and strap are asynchronous pins
`timescale 1ns/100ps
`default_nettype none
`include "cpsm_consts.svh"
module cpsm_top #(
  parameter int          NUM_LD           = 16,
  parameter int          POR_BLOCK_CYCLES = `CPSM_POR_BLOCK_US * `CPSM_CLK_MHZ,
  // arbitrary identification values
  parameter logic [7:0]  DEV_ID           = 8'h5A,
  parameter logic [7:0]  DEV_REV          = 8'h11
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [15:0]       ioAddr,
  input  wire logic [7:0]        ioWdata,
  input  wire logic              ioWr,
  input  wire logic              ioRd,
  input  wire logic              aen,
  output var  logic [7:0]        ioRdata,
  input  wire logic              hostResetInput,
  input  wire logic              strapSel,
  output var  logic              configMode,
  output var  logic [NUM_LD-1:0] ldActive,
  output var  logic [15:0]       cfgBase,
  output var  logic              hostBlocked
);

  ////////////////////////////////////////////////////////////////////////
  // local sizes and helpers

  localparam int CNT_W = $clog2(POR_BLOCK_CYCLES + 1);
  localparam int LD_W  = (NUM_LD > 1) ? $clog2(NUM_LD) : 1;
  localparam int GLB_N = 48;

  function automatic logic portHit(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] ofs
  );
    logic [15:0] target;
    target = 16'(base + ofs);
    return addr == target;
  endfunction

  function automatic logic ldInRange(input logic [7:0] ld);
    return 32'(ld) < NUM_LD;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [1:0] pinSync;
  logic       hostRstSync;
  logic       strapSync;

  cpsm_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock   (clock),
    .reset   (reset),
    .ce      (ce),
    .pinIn   ({hostResetInput, strapSel}),
    .pinSync (pinSync)
  );

  assign hostRstSync = pinSync[1];
  assign strapSync   = pinSync[0];

  ////////////////////////////////////////////////////////////////////////
  // state

  logic                  hostRstDly_reg;
  logic [CNT_W-1:0]      blockCnt_reg;
  logic                  blockFlag_reg;
  logic [7:0]            index_reg;
  logic [7:0]            ldn_reg;
  logic [7:0]            cfgBaseAddrLow_reg;
  logic [7:0]            cfgBaseAddrHigh_reg;
  logic [7:0]            ioRdata_reg;
  logic [NUM_LD-1:0]     ldActive_reg;
  logic [7:0]            globalMem [GLB_N];
  logic [7:0]            ldMem [NUM_LD][256];
  logic [7:0]            rdValue;

  cpsm_key_if keyBus ();

  cpsm_key_fsm u_key (
    .clock  (clock),
    .reset  (reset),
    .ce     (ce),
    .keyBus (keyBus.fsm)
  );

  ////////////////////////////////////////////////////////////////////////
  // decode

  logic            hardRst;
  logic            portOpen;
  logic            cfgHit;
  logic            dataHit;
  logic            cfgWr;
  logic            dataWr;
  logic            dataRd;
  logic            idxWr;
  logic            softRst;
  logic            strapLatch;
  logic            ldOk;
  logic [LD_W-1:0] ldSel;
  logic [15:0]     curBase;

  assign hardRst = hostRstSync;
  assign curBase = {cfgBaseAddrHigh_reg, cfgBaseAddrLow_reg};
  assign portOpen = !aen && !blockFlag_reg;
  assign cfgHit = portOpen && portHit(ioAddr, curBase, 16'h0000);
  assign dataHit = portOpen && keyBus.cfgMode
                   && portHit(ioAddr, curBase, `CPSM_DATA_PORT_OFS);
  assign cfgWr  = ioWr && cfgHit;
  assign dataWr = ioWr && dataHit;
  assign dataRd = ioRd && dataHit;
  // in configuration the config port doubles as index port; exit byte is not stored
  assign idxWr = cfgWr && keyBus.cfgMode && (ioWdata != `CPSM_KEY_EXIT);
  assign softRst = dataWr && (index_reg == `CPSM_IDX_CFG_CTRL)
                   && ioWdata[`CPSM_SOFT_RESET_BIT];
  assign strapLatch = (blockCnt_reg == CNT_W'(1))
                      || (hostRstDly_reg && !hostRstSync);
  assign ldOk  = ldInRange(ldn_reg);
  assign ldSel = ldn_reg[LD_W-1:0];

  assign keyBus.keyWrite  = cfgWr;
  assign keyBus.keyData   = ioWdata;
  assign keyBus.hardReset = hardRst;

  ////////////////////////////////////////////////////////////////////////
  // power-on access block

  always_ff @(posedge clock) begin
    if (reset) begin
      blockCnt_reg  <= CNT_W'(POR_BLOCK_CYCLES);
      blockFlag_reg <= 1'b1;
    end else if (ce && blockFlag_reg) begin
      blockCnt_reg <= blockCnt_reg - 1'b1;
      if (blockCnt_reg == CNT_W'(1)) begin
        blockFlag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      hostRstDly_reg <= 1'b0;
    end else if (ce) begin
      hostRstDly_reg <= hostRstSync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // config port base address

  always_ff @(posedge clock) begin
    if (reset) begin
      cfgBaseAddrLow_reg  <= `CPSM_BASE_LOW_STRAP_LO;
      cfgBaseAddrHigh_reg <= `CPSM_BASE_HIGH_BYTE;
    end else if (ce && !hardRst) begin
      if (strapLatch) begin
        cfgBaseAddrLow_reg  <= strapSync ? `CPSM_BASE_LOW_STRAP_HI
                                         : `CPSM_BASE_LOW_STRAP_LO;
        cfgBaseAddrHigh_reg <= `CPSM_BASE_HIGH_BYTE;
      end else if (dataWr) begin
        if (index_reg == `CPSM_IDX_BASE_LO) cfgBaseAddrLow_reg <= ioWdata;
        if (index_reg == `CPSM_IDX_BASE_HI) cfgBaseAddrHigh_reg <= ioWdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // index and logical device number

  always_ff @(posedge clock) begin
    if (reset) begin
      index_reg <= `CPSM_RST_BYTE;
    end else if (ce) begin
      if (hardRst) index_reg <= `CPSM_RST_BYTE;
      else if (idxWr) index_reg <= ioWdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      ldn_reg <= `CPSM_RST_BYTE;
    end else if (ce) begin
      if (hardRst || softRst) ldn_reg <= `CPSM_RST_BYTE;
      else if (dataWr && index_reg == `CPSM_IDX_LDN) ldn_reg <= ioWdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // activate bits and register storage

  always_ff @(posedge clock) begin
    if (reset) begin
      ldActive_reg <= '0;
    end else if (ce) begin
      if (hardRst || softRst) begin
        ldActive_reg <= '0;
      end else if (dataWr && ldOk && index_reg == `CPSM_IDX_ACTIVATE) begin
        ldActive_reg[ldSel] <= ioWdata[0];
      end
    end
  end

  // storage holds no reset state; only activate, number, index and base are reset
  always_ff @(posedge clock) begin
    if (ce && !hardRst && dataWr) begin
      if (index_reg < `CPSM_IDX_LD_FIRST) begin
        globalMem[index_reg[5:0]] <= ioWdata;
      end else if (ldOk && index_reg != `CPSM_IDX_ACTIVATE) begin
        ldMem[ldSel][index_reg] <= ioWdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data port read

  always_comb begin
    rdValue = `CPSM_RST_BYTE;
    case (index_reg)
      `CPSM_IDX_CFG_CTRL: rdValue = `CPSM_RST_BYTE;
      `CPSM_IDX_LDN:      rdValue = ldn_reg;
      `CPSM_IDX_DEV_ID:   rdValue = DEV_ID;
      `CPSM_IDX_DEV_REV:  rdValue = DEV_REV;
      `CPSM_IDX_BASE_LO:  rdValue = cfgBaseAddrLow_reg;
      `CPSM_IDX_BASE_HI:  rdValue = cfgBaseAddrHigh_reg;
      default: begin
        if (index_reg < `CPSM_IDX_LD_FIRST) begin
          rdValue = globalMem[index_reg[5:0]];
        end else if (!ldOk) begin
          rdValue = `CPSM_RST_BYTE;
        end else if (index_reg == `CPSM_IDX_ACTIVATE) begin
          rdValue = {7'h00, ldActive_reg[ldSel]};
        end else begin
          rdValue = ldMem[ldSel][index_reg];
        end
      end
    endcase
  end

  // read data stand one cycle only; config port and blocked reads give zero
  always_ff @(posedge clock) begin
    if (reset) begin
      ioRdata_reg <= `CPSM_RST_BYTE;
    end else if (ce) begin
      ioRdata_reg <= dataRd ? rdValue : `CPSM_RST_BYTE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign ioRdata     = ioRdata_reg;
  assign configMode  = keyBus.cfgMode;
  assign ldActive    = ldActive_reg;
  assign cfgBase     = curBase;
  assign hostBlocked = blockFlag_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_hard_reset;
    @(posedge clock) disable iff (reset)
    (ce && hardRst) |=> (!keyBus.cfgMode && ldActive_reg == '0 && ldn_reg == 8'h00);
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("hard reset not run");

  property p_strap_low;
    @(posedge clock) disable iff (reset)
    (ce && hostRstDly_reg && !hostRstSync && !strapSync)
      |=> cfgBase == `CPSM_BASE_STRAP_LO;
  endproperty
  a_strap_low: assert property (p_strap_low) else $error("strap low base wrong");

  property p_strap_high;
    @(posedge clock) disable iff (reset)
    (ce && hostRstDly_reg && !hostRstSync && strapSync)
      |=> cfgBase == `CPSM_BASE_STRAP_HI;
  endproperty
  a_strap_high: assert property (p_strap_high) else $error("strap high base wrong");

  property p_relocate;
    @(posedge clock) disable iff (reset)
    (ce && dataWr && !hardRst && !strapLatch && index_reg == `CPSM_IDX_BASE_LO)
      |=> cfgBaseAddrLow_reg == $past(ioWdata);
  endproperty
  a_relocate: assert property (p_relocate) else $error("base low not written");

  property p_aen;
    @(posedge clock) disable iff (reset)
    (ce && ioWr && aen && !hardRst)
      |=> ($stable(index_reg) && $stable(keyBus.keyState) && $stable(ldn_reg));
  endproperty
  a_aen: assert property (p_aen) else $error("dma cycle decoded");

  property p_run_ignore;
    @(posedge clock) disable iff (reset)
    (ce && ioWr && !keyBus.cfgMode && !hardRst)
      |=> ($stable(ldn_reg) && $stable(ldActive_reg) && $stable(index_reg));
  endproperty
  a_run_ignore: assert property (p_run_ignore) else $error("port acted in run");

  property p_read_ldn;
    @(posedge clock) disable iff (reset)
    (ce && dataRd && index_reg == `CPSM_IDX_LDN) |=> ioRdata_reg == $past(ldn_reg);
  endproperty
  a_read_ldn: assert property (p_read_ldn) else $error("data read wrong");

  property p_soft;
    @(posedge clock) disable iff (reset)
    (ce && softRst) |=> (ldn_reg == 8'h00 && ldActive_reg == '0);
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset not applied");

  property p_block;
    @(posedge clock) disable iff (reset)
    (blockFlag_reg && ioRd) |=> ioRdata_reg == 8'h00;
  endproperty
  a_block: assert property (p_block) else $error("access during block");

  c_soft: cover property (@(posedge clock) disable iff (reset) ce && softRst);
  c_move: cover property (@(posedge clock) disable iff (reset)
    ce && dataWr && index_reg == `CPSM_IDX_BASE_HI);

endmodule // cpsm_top
`default_nettype wire

// file: hw/cpsm_consts.svh
// constants of the configuration port state machine
// assumes inclusion by bare name from design files
`ifndef CPSM_CONSTS_SVH
`define CPSM_CONSTS_SVH
`define CPSM_CLK_MHZ 100
`define CPSM_POR_BLOCK_US 500
`define CPSM_KEY_ENTER 8'h55
`define CPSM_KEY_EXIT 8'hAA
`define CPSM_BASE_STRAP_LO 16'h03F0
`define CPSM_BASE_STRAP_HI 16'h0370
`define CPSM_BASE_HIGH_BYTE 8'h03
`define CPSM_BASE_LOW_STRAP_LO 8'hF0
`define CPSM_BASE_LOW_STRAP_HI 8'h70
`define CPSM_DATA_PORT_OFS 16'h0001
`define CPSM_IDX_CFG_CTRL 8'h02
`define CPSM_IDX_LDN 8'h07
`define CPSM_IDX_DEV_ID 8'h20
`define CPSM_IDX_DEV_REV 8'h21
`define CPSM_IDX_BASE_LO 8'h26
`define CPSM_IDX_BASE_HI 8'h27
`define CPSM_IDX_LD_FIRST 8'h30
`define CPSM_IDX_ACTIVATE 8'h30
`define CPSM_SOFT_RESET_BIT 0
`define CPSM_RST_BYTE 8'h00
`endif

// file: hw/cpsm_pkg.sv
// types of the configuration port state machine
// assumes nothing of its surroundings
package cpsm_pkg;
  // run and armed both count as run; armed holds one entry byte
  typedef enum logic [1:0] {
    KEY_RUN    = 2'b00,
    KEY_ARMED  = 2'b01,
    KEY_CONFIG = 2'b11
  } cpsm_key_state_type;
  typedef logic [7:0] cpsm_byte_type;
endpackage

// file: hw/cpsm_key_if.sv
// carrier between the port decoder and the key state machine
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface cpsm_key_if;
  logic                        keyWrite;
  cpsm_pkg::cpsm_byte_type     keyData;
  logic                        hardReset;
  logic                        cfgMode;
  cpsm_pkg::cpsm_key_state_type keyState;
  modport ctrl (output keyWrite, output keyData, output hardReset,
                input cfgMode, input keyState);
  modport fsm  (input keyWrite, input keyData, input hardReset,
                output cfgMode, output keyState);
endinterface
`default_nettype wire

// file: hw/cpsm_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to clock
`timescale 1ns/100ps
`default_nettype none
module cpsm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1_reg <= '0;
      pinSync    <= '0;
    end else if (ce) begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end
endmodule // cpsm_sync
`default_nettype wire

// file: hw/cpsm_key_fsm.sv
// key detector: run, armed and configuration states
// assumes writes to the config port arrive as one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
`include "cpsm_consts.svh"
module cpsm_key_fsm (
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  cpsm_key_if.fsm  keyBus
);
  cpsm_pkg::cpsm_key_state_type state_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= cpsm_pkg::KEY_RUN;
    end else if (ce) begin
      if (keyBus.hardReset) begin
        state_reg <= cpsm_pkg::KEY_RUN;
      end else if (keyBus.keyWrite) begin
        case (state_reg)
          cpsm_pkg::KEY_RUN: begin
            if (keyBus.keyData == `CPSM_KEY_ENTER) state_reg <= cpsm_pkg::KEY_ARMED;
          end
          cpsm_pkg::KEY_ARMED: begin
            if (keyBus.keyData == `CPSM_KEY_ENTER) state_reg <= cpsm_pkg::KEY_CONFIG;
            else state_reg <= cpsm_pkg::KEY_RUN;
          end
          cpsm_pkg::KEY_CONFIG: begin
            if (keyBus.keyData == `CPSM_KEY_EXIT) state_reg <= cpsm_pkg::KEY_RUN;
          end
          default: state_reg <= cpsm_pkg::KEY_RUN;
        endcase
      end
    end
  end

  assign keyBus.cfgMode  = state_reg[1];
  assign keyBus.keyState = state_reg;

  logic go;
  assign go = ce && keyBus.keyWrite && !keyBus.hardReset;

  property p_enter;
    @(posedge clock) disable iff (reset)
    (go && state_reg == cpsm_pkg::KEY_ARMED && keyBus.keyData == `CPSM_KEY_ENTER)
      |=> keyBus.cfgMode;
  endproperty
  a_enter: assert property (p_enter) else $error("second entry byte missed");
  property p_exit;
    @(posedge clock) disable iff (reset)
    (go && keyBus.cfgMode && keyBus.keyData == `CPSM_KEY_EXIT) |=> !keyBus.cfgMode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit byte ignored");
  property p_arm;
    @(posedge clock) disable iff (reset)
    (go && state_reg == cpsm_pkg::KEY_RUN && keyBus.keyData == `CPSM_KEY_ENTER)
      |=> state_reg == cpsm_pkg::KEY_ARMED;
  endproperty
  a_arm: assert property (p_arm) else $error("run did not accept key");
  property p_restart;
    @(posedge clock) disable iff (reset)
    (go && state_reg == cpsm_pkg::KEY_ARMED && keyBus.keyData != `CPSM_KEY_ENTER)
      |=> state_reg == cpsm_pkg::KEY_RUN;
  endproperty
  a_restart: assert property (p_restart) else $error("key detect not restarted");
  c_enter: cover property (@(posedge clock) disable iff (reset) $rose(keyBus.cfgMode));
  c_exit: cover property (@(posedge clock) disable iff (reset) $fell(keyBus.cfgMode));
endmodule // cpsm_key_fsm
`default_nettype wire

// file: verif/cpsm_host_model.sv
// host bus model: one-cycle i/o strobes and the key and index/data sequences
// assumes the unit answers reads one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module cpsm_host_model (
  input  wire logic        clock,
  input  wire logic [7:0]  ioRdata,
  output var  logic [15:0] ioAddr,
  output var  logic [7:0]  ioWdata,
  output var  logic        ioWr,
  output var  logic        ioRd,
  output var  logic        aen
);
  initial begin
    ioAddr = 16'h0000;
    ioWdata = 8'h00;
    ioWr = 1'b0;
    ioRd = 1'b0;
    aen = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  // after a cycle the address and data lines show the inverse, not stale values
  task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic w,
                     input logic dma);
    @(posedge clock);
    ioAddr <= a;
    ioWdata <= d;
    ioWr <= w;
    ioRd <= !w;
    aen <= dma;
    @(posedge clock);
    ioWr <= 1'b0;
    ioRd <= 1'b0;
    aen <= 1'b0;
    ioAddr <= ~a;
    ioWdata <= ~d;
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1, 1'b0);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cyc(a, 8'h00, 1'b0, 1'b0);
    d = ioRdata;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic enter(input logic [15:0] b);
    wr(b, 8'h55);
    wr(b, 8'h55);
  endtask
  task automatic leave(input logic [15:0] b);
    wr(b, 8'hAA);
  endtask
  task automatic setReg(input logic [15:0] b, input logic [7:0] i, input logic [7:0] d);
    wr(b, i);
    wr(b + 16'h0001, d);
  endtask
  task automatic getReg(input logic [15:0] b, input logic [7:0] i, output logic [7:0] d);
    wr(b, i);
    rd(b + 16'h0001, d);
  endtask
endmodule // cpsm_host_model
`default_nettype wire

// file: verif/config_port_state_machine_test.sv
// self-checking bench of the configuration port state machine
// assumes the host model drives the i/o port; reset pins come from here
`timescale 1ns/100ps
`default_nettype none
module config_port_state_machine_test;
  logic        clock;
  logic        reset;
  logic        ce;
  logic        hostResetInput;
  logic        strapSel;
  logic [15:0] ioAddr;
  logic [7:0]  ioWdata;
  logic        ioWr;
  logic        ioRd;
  logic        aen;
  logic [7:0]  ioRdata;
  logic        configMode;
  logic [15:0] ldActive;
  logic [15:0] cfgBase;
  logic        hostBlocked;
  logic [7:0]  rdv;
  int          failures;
  int          checksDone;

  cpsm_host_model i_host (.clock(clock), .ioRdata(ioRdata), .ioAddr(ioAddr),
    .ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd), .aen(aen));

  cpsm_top #(.NUM_LD(16), .POR_BLOCK_CYCLES(20)) i_dut (.clock(clock), .reset(reset),
    .ce(ce), .ioAddr(ioAddr), .ioWdata(ioWdata), .ioWr(ioWr), .ioRd(ioRd),
    .aen(aen), .ioRdata(ioRdata), .hostResetInput(hostResetInput),
    .strapSel(strapSel), .configMode(configMode), .ldActive(ldActive),
    .cfgBase(cfgBase), .hostBlocked(hostBlocked));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (failures == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic waitFree;
    for (int i = 0; i < 100 && hostBlocked !== 1'b0; i++) @(posedge clock);
    #1;
    if (hostBlocked !== 1'b0) begin
      failures++;
      summarize();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    checksDone = 0;
    reset = 1'b1;
    ce = 1'b1;
    hostResetInput = 1'b0;
    strapSel = 1'b0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("mode", {15'h0000, configMode}, 16'h0000);
    check("ldActive", ldActive, 16'h0000);
    check("blocked", {15'h0000, hostBlocked}, 16'h0001);
    i_host.rd(16'h03F1, rdv);
    check("blocked read", {8'h00, rdv}, 16'h0000);
    i_host.enter(16'h03F0);
    check("mode blocked", {15'h0000, configMode}, 16'h0000);
    waitFree();
    check("base strap0", cfgBase, 16'h03F0);
    // key during dma cycles must not count
    i_host.cyc(16'h03F0, 8'h55, 1'b1, 1'b1);
    i_host.cyc(16'h03F0, 8'h55, 1'b1, 1'b1);
    check("mode dma", {15'h0000, configMode}, 16'h0000);
    // index/data writes in run: ldn must stay 0
    i_host.setReg(16'h03F0, 8'h07, 8'h05);
    // a foreign byte between the key bytes restarts detection
    i_host.wr(16'h03F0, 8'h55);
    i_host.wr(16'h03F0, 8'h12);
    i_host.wr(16'h03F0, 8'h55);
    check("mode broken key", {15'h0000, configMode}, 16'h0000);
    i_host.wr(16'h03F0, 8'h55);
    check("mode key", {15'h0000, configMode}, 16'h0001);
    i_host.getReg(16'h03F0, 8'h07, rdv);
    check("ldn run write", {8'h00, rdv}, 16'h0000);
    i_host.setReg(16'h03F0, 8'h07, 8'h08);
    i_host.setReg(16'h03F0, 8'h30, 8'h01);
    check("ld8 active", ldActive, 16'h0100);
    i_host.getReg(16'h03F0, 8'h30, rdv);
    check("ld8 readback", {8'h00, rdv}, 16'h0001);
    i_host.rd(16'h03F0, rdv);
    check("cfg port read", {8'h00, rdv}, 16'h0000);
    i_host.setReg(16'h03F0, 8'h22, 8'hA5);
    i_host.getReg(16'h03F0, 8'h22, rdv);
    check("global reg", {8'h00, rdv}, 16'h00A5);
    i_host.setReg(16'h03F0, 8'h02, 8'h01);
    check("soft ldActive", ldActive, 16'h0000);
    check("soft mode", {15'h0000, configMode}, 16'h0001);
    i_host.getReg(16'h03F0, 8'h07, rdv);
    check("soft ldn", {8'h00, rdv}, 16'h0000);
    // relocation: each byte moves the port at once, ending at 0x02E0
    i_host.setReg(16'h03F0, 8'h26, 8'hE0);
    check("base low moved", cfgBase, 16'h03E0);
    i_host.setReg(16'h03E0, 8'h27, 8'h02);
    check("base moved", cfgBase, 16'h02E0);
    i_host.getReg(16'h02E0, 8'h26, rdv);
    check("base low", {8'h00, rdv}, 16'h00E0);
    i_host.leave(16'h02E0);
    check("mode exit", {15'h0000, configMode}, 16'h0000);
    i_host.leave(16'h02E0);
    i_host.enter(16'h02E0);
    check("mode reenter", {15'h0000, configMode}, 16'h0001);
    i_host.setReg(16'h02E0, 8'h07, 8'h02);
    i_host.setReg(16'h02E0, 8'h30, 8'h01);
    check("ld2 active", ldActive, 16'h0004);
    // hard reset with strap high
    @(posedge clock);
    hostResetInput <= 1'b1;
    strapSel <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    check("hard mode", {15'h0000, configMode}, 16'h0000);
    check("hard ldActive", ldActive, 16'h0000);
    @(posedge clock);
    hostResetInput <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    check("base strap1", cfgBase, 16'h0370);
    i_host.enter(16'h0370);
    check("mode strap1", {15'h0000, configMode}, 16'h0001);
    // clock enable low: the exit byte must not be taken
    @(posedge clock);
    ce <= 1'b0;
    i_host.leave(16'h0370);
    check("mode frozen", {15'h0000, configMode}, 16'h0001);
    @(posedge clock);
    ce <= 1'b1;
    i_host.leave(16'h0370);
    check("mode strap1 exit", {15'h0000, configMode}, 16'h0000);
    // hard reset with strap low brings the port back to 0x03F0
    @(posedge clock);
    hostResetInput <= 1'b1;
    strapSel <= 1'b0;
    repeat (6) @(posedge clock);
    hostResetInput <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    check("base strap0 again", cfgBase, 16'h03F0);
    summarize();
  end
endmodule // config_port_state_machine_test
`default_nettype wire
